// ===== sync_monitor.sv
// Purpose: Port checker for the sync pulse block
// Assumes: CTRL writes are decoded from the bus ports
// Notes: Bound to the design after the module
`timescale 1ns/1ps
module sync_monitor
#(
    parameter int PULSE_A_CYCLES = 8,
    parameter int PULSE_B_CYCLES = 10,
    parameter int BLANK_A_CYCLES = 14,
    parameter int BLANK_B_CYCLES = 18
)
(
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Sync pair and events
    input wire logic sync_p_i,
    input wire logic sync_n_i,
    input wire logic sync_p_o,
    input wire logic sync_n_o,
    input wire logic sync_oe,
    input wire logic sample_strobe,
    input wire logic acq_active
);
    // ----
    // Helper state
    // ----
    logic wr_q;
    logic act;
    logic [4:0] ctrl_q;
    logic [15:0] hi_cnt;
    logic [15:0] gap_cnt;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    assign act = sync_oe && (ctrl_q[3] ? !sync_p_o : sync_p_o);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            ctrl_q <= 5'h00;
            hi_cnt <= 16'h0000;
            gap_cnt <= 16'h0000;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0000;
            if (wr_q)
                ctrl_q <= hwdata[4:0];
            hi_cnt <= act ? hi_cnt + 16'h0001 : 16'h0000;
            gap_cnt <= (sample_strobe || !acq_active) ? 16'h0000 : gap_cnt + 16'h0001;
        end
    end
    sequence pulse_start;
        $rose(act);
    endsequence
    sequence pulse_quiet;
        !act;
    endsequence
    // ----
    // Assertions
    // ----
    a_pulse_width: assert property ($fell(act) && sync_oe |->
        hi_cnt == (ctrl_q[3] ? 16'(PULSE_B_CYCLES) : 16'(PULSE_A_CYCLES))) else $error("pulse width wrong");
    a_start_pulse: assert property ($rose(acq_active) && ctrl_q[1] && !ctrl_q[2] |-> pulse_start)
        else $error("no start pulse");
    a_no_start: assert property ($rose(acq_active) && ctrl_q[1] && ctrl_q[2] |-> pulse_quiet ##1 pulse_quiet)
        else $error("start pulse in foreign mode");
    a_end_pulse: assert property (sample_strobe && sync_oe && !ctrl_q[2] |-> ##[0:1] pulse_start)
        else $error("no pulse at interval end");
    a_mid_quiet: assert property (sample_strobe && sync_oe && ctrl_q[2] |-> pulse_quiet)
        else $error("pulse at interval end in foreign mode");
    a_lines_differ: assert property (sync_oe |-> sync_p_o != sync_n_o)
        else $error("pair not differential");
    a_first_quiet: assert property ($rose(acq_active) && !ctrl_q[1] && ctrl_q[4] |-> !sample_strobe [*2])
        else $error("sample on first trigger");
    a_blank_gap: assert property (sample_strobe && !ctrl_q[1] && ctrl_q[4] |->
        gap_cnt >= (ctrl_q[3] ? 16'(BLANK_B_CYCLES - 1) : 16'(BLANK_A_CYCLES - 1))) else $error("trigger inside blanking");
endmodule

bind sync_pulse_master_slave sync_monitor #(.PULSE_A_CYCLES(PULSE_A_CYCLES), .PULSE_B_CYCLES(PULSE_B_CYCLES),
    .BLANK_A_CYCLES(BLANK_A_CYCLES), .BLANK_B_CYCLES(BLANK_B_CYCLES)) mon_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sync_p_i(sync_p_i), .sync_n_i(sync_n_i),
    .sync_p_o(sync_p_o), .sync_n_o(sync_n_o), .sync_oe(sync_oe), .sample_strobe(sample_strobe), .acq_active(acq_active));

// ===== sync_peer.sv
// Purpose: Far-side instrument on the sync pair
// Assumes: Bench gives the logic level and the variant
// Notes: Peer lets go of the pair while the device drives
`timescale 1ns/1ps
module sync_peer
(
    // Bench request
    input wire logic lvl,
    input wire logic var_b,
    // Device drive
    input wire logic dev_p,
    input wire logic dev_n,
    input wire logic dev_oe,
    // Resolved pair
    output logic line_p,
    output logic line_n
);
    always_comb
    begin
        line_p = dev_oe ? dev_p : (var_b ? !lvl : lvl);
        line_n = dev_oe ? dev_n : (var_b ? lvl : !lvl);
    end
endmodule

// ===== sync_pkg.sv
// Purpose: Shared constants and types for the sync pulse master/slave block
// Assumes: 100 MHz system clock, AHB-Lite register access
// Notes: Durations are converted to cycles by rounding up

package sync_pkg;

    // ------------------------------------------------------------
    // Clock and durations
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 100000000;
    localparam longint US_PER_S = 1000000;
    localparam int PULSE_A_US = 40;
    localparam int PULSE_B_US = 50;
    localparam int BLANK_A_US = 64;
    localparam int BLANK_B_US = 100;

    function automatic int us_to_cyc(input int us);
        longint c;
        c = (longint'(us) * CLK_HZ + US_PER_S - 1) / US_PER_S;
        if (c < 1)
        begin
            c = 1;
        end
        return int'(c);
    endfunction

    localparam int PULSE_A_CYC = us_to_cyc(PULSE_A_US);
    localparam int PULSE_B_CYC = us_to_cyc(PULSE_B_US);
    localparam int BLANK_A_CYC = us_to_cyc(BLANK_A_US);
    localparam int BLANK_B_CYC = us_to_cyc(BLANK_B_US);
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int AW = 12;
    localparam logic [AW-1:0] OFF_CTRL = 12'h000;
    localparam logic [AW-1:0] OFF_INTERVAL = 12'h004;
    localparam logic [AW-1:0] OFF_STATUS = 12'h008;
    localparam logic [AW-1:0] OFF_SAMPLES = 12'h00c;
    localparam int CTRL_W = 5;
    localparam int CTRL_EN = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_FOREIGN = 2;
    localparam int CTRL_VAR_B = 3;
    localparam int CTRL_PER_PULSE = 4;
    localparam int STAT_ARMED = 0;
    localparam int STAT_RUN = 1;
    localparam int STAT_LEVEL = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [31:0] INTERVAL_RST = 32'h0000_2710;
    localparam logic [31:0] INTERVAL_MIN = 32'h0000_0002;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        FSM_IDLE = 3'h1,
        FSM_ARMED = 3'h2,
        FSM_RUN = 3'h4
    } fsm_e;

endpackage

// ===== sync_pulse_master_slave.sv
// Purpose: Sampling sync on a differential pair, as pulse master or edge slave
// Assumes: Single clock hclk, async active-low reset, AHB-Lite slave
// Notes: Line inputs are synchronised by two flip-flops each
//
// Contract
// - Variant A master pulses last 40 us on the pair.
// - Variant A like-instrument master pulses each interval end plus once at start.
// - Variant A foreign-sensor master pulses at each interval midpoint.
// - Variant A slave triggers on any edge of the received level.
// - Variant A ignores input transitions for 64 us after an accepted trigger.
// - Variant A reads high when positive line exceeds negative line.
// - Variant B master pulses last 50 us.
// - Variant B like-instrument master pulses each interval end plus once at start.
// - Variant B foreign-sensor master pulses at each interval middle.
// - Variant B slave triggers only on falling edges.
// - Variant B blanks the input 100 us after each accepted trigger.
// - Variant B reads high when negative line exceeds positive line.
// - Started slave waits for first master pulse; slaves start before master.
// - Per-pulse mode: first trigger starts averaging, later ones emit samples.
// - Start-only mode: first trigger starts sampling, later transitions ignored.

`timescale 1ns/1ps

module sync_pulse_master_slave
#(
    parameter int PULSE_A_CYCLES = sync_pkg::PULSE_A_CYC,
    parameter int PULSE_B_CYCLES = sync_pkg::PULSE_B_CYC,
    parameter int BLANK_A_CYCLES = sync_pkg::BLANK_A_CYC,
    parameter int BLANK_B_CYCLES = sync_pkg::BLANK_B_CYC
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Differential sync pair
    input wire logic sync_p_i,
    input wire logic sync_n_i,
    output logic sync_p_o,
    output logic sync_n_o,
    output logic sync_oe,
    // Sampling events
    output logic sample_strobe,
    output logic acq_active
);
    import sync_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [31:0] interval;
        logic [31:0] samples;
        fsm_e fsm;
        logic [31:0] icnt;
        logic [CNT_W-1:0] pcnt;
        logic [CNT_W-1:0] bcnt;
        logic s1p;
        logic s2p;
        logic s1n;
        logic s2n;
        logic lvl;
        logic wr_pend;
        logic [AW-1:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic sync_p;
        logic sync_n;
        logic sync_oe;
        logic strobe;
        logic active;
    } state_s;

    localparam state_s STATE_RST = '{
        ctrl: CTRL_RST,
        interval: INTERVAL_RST,
        samples: 32'h0000_0000,
        fsm: FSM_IDLE,
        icnt: 32'h0000_0000,
        pcnt: '0,
        bcnt: '0,
        s1p: 1'b0,
        s2p: 1'b0,
        s1n: 1'b0,
        s2n: 1'b0,
        lvl: 1'b0,
        wr_pend: 1'b0,
        wr_addr: '0,
        hrdata: 32'h0000_0000,
        hreadyout: 1'b1,
        hresp: 1'b0,
        sync_p: 1'b0,
        sync_n: 1'b0,
        sync_oe: 1'b0,
        strobe: 1'b0,
        active: 1'b0
    };

    localparam logic [CNT_W-1:0] PULSE_A_LD = CNT_W'(PULSE_A_CYCLES);
    localparam logic [CNT_W-1:0] PULSE_B_LD = CNT_W'(PULSE_B_CYCLES);
    localparam logic [CNT_W-1:0] BLANK_A_LD = CNT_W'(BLANK_A_CYCLES);
    localparam logic [CNT_W-1:0] BLANK_B_LD = CNT_W'(BLANK_B_CYCLES);

    state_s state_reg;
    state_s state_next;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic is_off(input logic [31:0] a, input logic [AW-1:0] off);
        return (a[31:AW] == '0) && (a[AW-1:0] == off);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic var_b;
        logic master;
        logic foreign;
        logic per_pulse;
        logic en;
        logic hi;
        logic lo;
        logic lvl_new;
        logic trig;
        logic accept;
        logic fire;
        logic last;
        logic on;
        logic [31:0] wa;
        state_next = state_reg;
        var_b = state_reg.ctrl[CTRL_VAR_B];
        master = state_reg.ctrl[CTRL_MASTER];
        foreign = state_reg.ctrl[CTRL_FOREIGN];
        per_pulse = state_reg.ctrl[CTRL_PER_PULSE];
        en = state_reg.ctrl[CTRL_EN];
        fire = 1'b0;
        last = 1'b0;
        on = 1'b0;
        wa = {{(32-AW){1'b0}}, state_reg.wr_addr};
        state_next.strobe = 1'b0;
        state_next.hreadyout = 1'b1;
        state_next.hresp = 1'b0;

        // Line synchronisers
        state_next.s1p = sync_p_i;
        state_next.s2p = state_reg.s1p;
        state_next.s1n = sync_n_i;
        state_next.s2n = state_reg.s1n;

        // Differential level, held while both lines agree
        if (var_b)
        begin
            hi = state_reg.s2n & ~state_reg.s2p;
            lo = state_reg.s2p & ~state_reg.s2n;
        end
        else
        begin
            hi = state_reg.s2p & ~state_reg.s2n;
            lo = state_reg.s2n & ~state_reg.s2p;
        end
        lvl_new = hi ? 1'b1 : (lo ? 1'b0 : state_reg.lvl);
        state_next.lvl = lvl_new;

        // Edge selection
        if (var_b)
        begin
            trig = state_reg.lvl & ~lvl_new;
        end
        else
        begin
            trig = state_reg.lvl ^ lvl_new;
        end

        // Blanking window
        if (state_reg.bcnt != '0)
        begin
            state_next.bcnt = state_reg.bcnt - 1'b1;
        end
        accept = trig && (state_reg.bcnt == '0) && en && !master &&
                 ((state_reg.fsm == FSM_ARMED) || ((state_reg.fsm == FSM_RUN) && per_pulse));
        if (accept)
        begin
            state_next.bcnt = var_b ? BLANK_B_LD : BLANK_A_LD;
        end

        // Sequencer
        case (state_reg.fsm)
            FSM_IDLE:
            begin
                if (en)
                begin
                    state_next.icnt = 32'h0000_0000;
                    if (master)
                    begin
                        state_next.fsm = FSM_RUN;
                        fire = !foreign;
                    end
                    else
                    begin
                        state_next.fsm = FSM_ARMED;
                    end
                end
            end
            FSM_ARMED:
            begin
                if (!en)
                begin
                    state_next.fsm = FSM_IDLE;
                end
                else if (accept)
                begin
                    state_next.fsm = FSM_RUN;
                    state_next.icnt = 32'h0000_0000;
                end
            end
            FSM_RUN:
            begin
                if (!en)
                begin
                    state_next.fsm = FSM_IDLE;
                end
                else if (master || !per_pulse)
                begin
                    last = state_reg.icnt >= (state_reg.interval - 32'h0000_0001);
                    state_next.icnt = last ? 32'h0000_0000 : state_reg.icnt + 32'h0000_0001;
                    state_next.strobe = last;
                    if (master && !foreign && last)
                    begin
                        fire = 1'b1;
                    end
                    if (master && foreign && (state_reg.icnt == {1'b0, state_reg.interval[31:1]}))
                    begin
                        fire = 1'b1;
                    end
                end
                else
                begin
                    state_next.strobe = accept;
                end
            end
            default:
            begin
                state_next.fsm = FSM_IDLE;
            end
        endcase
        if (state_next.strobe)
        begin
            state_next.samples = state_reg.samples + 32'h0000_0001;
        end
        state_next.active = (state_next.fsm == FSM_RUN);

        // Pulse generator
        if (state_reg.pcnt != '0)
        begin
            state_next.pcnt = state_reg.pcnt - 1'b1;
        end
        if (fire)
        begin
            state_next.pcnt = var_b ? PULSE_B_LD : PULSE_A_LD;
        end
        on = (state_next.pcnt != '0);
        state_next.sync_p = var_b ? ~on : on;
        state_next.sync_n = var_b ? on : ~on;
        state_next.sync_oe = master && (state_next.fsm != FSM_IDLE);

        // Bus write data phase
        if (state_reg.wr_pend)
        begin
            if (is_off(wa, OFF_CTRL))
            begin
                state_next.ctrl = hwdata[CTRL_W-1:0];
            end
            else if (is_off(wa, OFF_INTERVAL))
            begin
                state_next.interval = (hwdata < INTERVAL_MIN) ? INTERVAL_MIN : hwdata;
            end
        end

        // Bus address phase
        state_next.wr_pend = 1'b0;
        state_next.hrdata = 32'h0000_0000;
        if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]))
        begin
            if (hwrite)
            begin
                state_next.wr_pend = 1'b1;
                state_next.wr_addr = haddr[AW-1:0];
            end
            else if (is_off(haddr, OFF_CTRL))
            begin
                state_next.hrdata = {{(32-CTRL_W){1'b0}}, state_next.ctrl};
            end
            else if (is_off(haddr, OFF_INTERVAL))
            begin
                state_next.hrdata = state_next.interval;
            end
            else if (is_off(haddr, OFF_STATUS))
            begin
                state_next.hrdata[STAT_ARMED] = (state_reg.fsm == FSM_ARMED);
                state_next.hrdata[STAT_RUN] = (state_reg.fsm == FSM_RUN);
                state_next.hrdata[STAT_LEVEL] = state_reg.lvl;
            end
            else if (is_off(haddr, OFF_SAMPLES))
            begin
                state_next.hrdata = state_reg.samples;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= STATE_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = state_reg.hrdata;
    assign hreadyout = state_reg.hreadyout;
    assign hresp = state_reg.hresp;
    assign sync_p_o = state_reg.sync_p;
    assign sync_n_o = state_reg.sync_n;
    assign sync_oe = state_reg.sync_oe;
    assign sample_strobe = state_reg.strobe;
    assign acq_active = state_reg.active;

endmodule

// ===== sync_pulse_master_slave_test.sv
// Purpose: Self-checking bench for the sync pulse block
// Assumes: Short pulse and blanking counts
// Notes: Random intervals and edge gaps from a fixed seed
`timescale 1ns/1ps
module sync_pulse_master_slave_test;
    import sync_pkg::*;
    localparam int PA = 8;
    localparam int PB = 10;
    localparam int BA = 14;
    localparam int BB = 18;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, lvl, var_b, act, act_q;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic line_p, line_n, sync_p_o, sync_n_o, sync_oe, sample_strobe, acq_active;
    int n_mismatch, compares, cyc, np, ns, tp, ts, dp;
    assign hready = hreadyout;
    assign act = sync_oe && (var_b ? !line_p : line_p);
    sync_pulse_master_slave #(.PULSE_A_CYCLES(PA), .PULSE_B_CYCLES(PB), .BLANK_A_CYCLES(BA), .BLANK_B_CYCLES(BB))
    dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sync_p_i(line_p), .sync_n_i(line_n), .sync_p_o(sync_p_o), .sync_n_o(sync_n_o), .sync_oe(sync_oe),
        .sample_strobe(sample_strobe), .acq_active(acq_active));
    sync_peer peer_u (.lvl(lvl), .var_b(var_b), .dev_p(sync_p_o), .dev_n(sync_n_o), .dev_oe(sync_oe),
        .line_p(line_p), .line_n(line_n));
    // ----
    // Tasks and functions
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        check(hresp, 1'b0);
    endtask
    function automatic logic [31:0] near(input int a, input int b);
        return {31'h0, (a - b <= 1) && (b - a <= 1)};
    endfunction
    function automatic logic takes(input logic vb, input logic nl, input int dt);
        return (vb ? !nl : 1'b1) && dt > (vb ? BB : BA);
    endfunction
    task automatic master_run(input logic vb, input logic fr);
        int iv;
        iv = 24 + 2 * int'($urandom % 8);
        var_b <= vb;
        bus(1'b1, OFF_INTERVAL, iv);
        bus(1'b1, OFF_CTRL, {28'h0, vb, fr, 2'h2});
        np = 0;
        bus(1'b1, OFF_CTRL, {28'h0, vb, fr, 2'h3});
        repeat (iv * 7 / 2) @(posedge hclk);
        check(np, fr ? 3 : 4);
        check(dp, iv);
        check(near(ts - tp, fr ? iv / 2 : 0), 32'h1);
        bus(1'b1, OFF_CTRL, 32'h0);
    endtask
    task automatic slave_run(input logic vb, input logic pp);
        int t, tacc, acc, s0, g;
        logic nl;
        t = 0;
        tacc = -1000;
        acc = 0;
        var_b <= vb;
        bus(1'b1, OFF_INTERVAL, 32'd5000);
        bus(1'b1, OFF_CTRL, {27'h0, pp, vb, 3'h0});
        repeat (6) @(posedge hclk);
        bus(1'b1, OFF_CTRL, {27'h0, pp, vb, 3'h1});
        @(posedge hclk);
        bus(1'b0, OFF_STATUS, 32'h0);
        check(rd[1:0], 2'h1);
        s0 = ns;
        for (int k = 0; k < 12; k++)
        begin
            nl = !lvl;
            if (takes(vb, nl, t - tacc))
            begin
                acc++;
                tacc = t;
            end
            lvl <= nl;
            g = ($urandom % 2) ? 4 : 30 + int'($urandom % 8);
            repeat (g) @(posedge hclk);
            t += g;
        end
        repeat (10) @(posedge hclk);
        check(acq_active, acc > 0);
        check(ns - s0, (pp && acc > 0) ? acc - 1 : 0);
        bus(1'b0, OFF_STATUS, 32'h0);
        check(rd[2], lvl);
        bus(1'b1, OFF_CTRL, 32'h0);
    endtask
    // ----
    // Clock, monitors and sequence
    // ----
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cyc++;
        if (act && !act_q)
        begin
            np++;
            dp = cyc - tp;
            tp = cyc;
        end
        if (sample_strobe === 1'b1)
        begin
            ns++;
            ts = cyc;
        end
        act_q = act;
    end
    initial
    begin
        #400000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        lvl = 1'b0;
        var_b = 1'b0;
        act_q = 1'b0;
        void'($urandom(32'hda8547e7));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, OFF_CTRL, 32'h0);
        check(rd, {27'h0, CTRL_RST});
        bus(1'b0, OFF_INTERVAL, 32'h0);
        check(rd, INTERVAL_RST);
        bus(1'b1, 12'h010, $urandom);
        bus(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, OFF_INTERVAL, 32'h1);
        bus(1'b0, OFF_INTERVAL, 32'h0);
        check(rd, INTERVAL_MIN);
        for (int m = 0; m < 4; m++)
            slave_run(m[1], m[0]);
        for (int m = 0; m < 4; m++)
            master_run(m[1], m[0]);
        complete_run();
    end
endmodule
